// ### rtl/peripheral_port_serial_config.sv
/*
 Peripheral serial port with its setup registers, a two-entry buffer
 on each data direction and a Wishbone classic slave.
 Assumes RXD and CYCLE_START are synchronous to CLOCK.
*/
`timescale 1ns/1ps
`default_nettype none

module buf2
#(
   parameter int W = 8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Write side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // Read side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   logic [W-1:0] mem_q [2];
   logic wr_q;
   logic rd_q;
   logic [1:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         cnt_q <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            mem_q[wr_q] <= in_data;
            wr_q <= ~wr_q;
         end
         if (pop)
            rd_q <= ~rd_q;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule // buf2

module peripheral_port_serial_config
#(
   parameter int CLK_HZ = 125000000,
   parameter int DIV_W = 20,
   parameter int AW = 12
)
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // Wishbone slave
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [AW-1:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   // Controller cycle
   input wire logic CYCLE_START,
   // Serial line and state
   input wire logic RXD,
   output logic TXD,
   output logic SETTINGS_CHANGING,
   output logic PBUS_MODE
);
   if (CLK_HZ / port_cfg_pkg::RATE_LOW >= 2 ** DIV_W || CLK_HZ / port_cfg_pkg::RATE_HIGH < 4
       || AW < 11)
      $error("CLK_HZ, DIV_W or AW out of range");

   logic [DIV_W-1:0] div_tab [11];
   for (genvar g = 0; g <= 10; g++)
   begin : g_div
      assign div_tab[g] = DIV_W'(CLK_HZ / port_cfg_pkg::baud_of(8'(g)));
   end

   logic [15:0] fmt_q;
   logic [15:0] rate_q;
   logic imm_q;
   logic bits8_q;
   logic stop1_q;
   logic [1:0] par_q;
   logic [DIV_W-1:0] div_q;
   logic perr_q;
   logic ferr_q;
   logic ovr_q;
   port_cfg_pkg::line_state_e tx_st_q;
   port_cfg_pkg::line_state_e rx_st_q;

   // Bus decode
   logic req;
   logic go;
   logic wr;
   logic [7:0] idx;
   logic mapped;
   logic tx_in_ready;
   logic rx_valid;
   logic [7:0] rx_data;
   logic [31:0] rd_data;
   assign req = CYC_I && STB_I && !ACK_O;
   assign idx = ADR_I[9:2];
   assign mapped = (ADR_I[AW-1:10] == '0) && (ADR_I[1:0] == 2'h0);
   assign go = req && !(mapped && idx == port_cfg_pkg::IDX_DATA && WE_I && SEL_I[0]
                        && !tx_in_ready);
   assign wr = go && WE_I && mapped;

   logic cfg_wr;
   logic instr_wr;
   logic tx_push;
   logic rx_pop;
   logic err_clr;
   assign cfg_wr = wr && (idx == port_cfg_pkg::IDX_FMT || idx == port_cfg_pkg::IDX_RATE);
   assign instr_wr = wr && idx == port_cfg_pkg::IDX_CTRL && SEL_I[0] && DAT_I[0];
   assign tx_push = wr && idx == port_cfg_pkg::IDX_DATA && SEL_I[0];
   assign rx_pop = go && !WE_I && mapped && idx == port_cfg_pkg::IDX_DATA;
   assign err_clr = wr && idx == port_cfg_pkg::IDX_STAT && SEL_I[0];

   always_comb
   begin
      rd_data = '0;
      if (mapped)
      begin
         unique case (idx)
            port_cfg_pkg::IDX_FMT: rd_data[15:0] = fmt_q;
            port_cfg_pkg::IDX_RATE: rd_data[15:0] = rate_q;
            port_cfg_pkg::IDX_DATA: rd_data[port_cfg_pkg::RX_VALID_BIT:0] = {rx_valid, rx_data};
            port_cfg_pkg::IDX_STAT:
            begin
               rd_data[port_cfg_pkg::ST_TXRDY] = tx_in_ready;
               rd_data[port_cfg_pkg::ST_RXVAL] = rx_valid;
               rd_data[port_cfg_pkg::ST_CHG] = SETTINGS_CHANGING;
               rd_data[port_cfg_pkg::ST_PERR] = perr_q;
               rd_data[port_cfg_pkg::ST_FERR] = ferr_q;
               rd_data[port_cfg_pkg::ST_OVR] = ovr_q;
            end
            port_cfg_pkg::IDX_CTRL: rd_data[5:0] = {PBUS_MODE, bits8_q, stop1_q, par_q, imm_q};
            default: rd_data = '0;
         endcase
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         ACK_O <= 1'b0;
         DAT_O <= '0;
      end
      else
      begin
         ACK_O <= go;
         if (go && !WE_I)
            DAT_O <= rd_data;
      end
   end

   // Stored setup words
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         fmt_q <= port_cfg_pkg::FMT_RST;
         rate_q <= port_cfg_pkg::RATE_RST;
      end
      else if (cfg_wr)
      begin
         for (int b = 0; b < 2; b++)
         begin
            if (SEL_I[b] && idx == port_cfg_pkg::IDX_FMT)
               fmt_q[8*b +: 8] <= DAT_I[8*b +: 8];
            if (SEL_I[b] && idx == port_cfg_pkg::IDX_RATE)
               rate_q[8*b +: 8] <= DAT_I[8*b +: 8];
         end
      end
   end

   // Effective settings from the stored words
   logic [3:0] mode;
   logic host;
   logic cust;
   logic [7:0] e_rate;
   logic [DIV_W-1:0] e_div;
   assign mode = fmt_q[port_cfg_pkg::MODE_LSB +: 4];
   assign host = (mode == port_cfg_pkg::MODE_HOST0) || (mode == port_cfg_pkg::MODE_HOST5);
   assign cust = fmt_q[port_cfg_pkg::SEL_BIT] && host;
   assign e_rate = cust ? rate_q[7:0] : port_cfg_pkg::RATE_STD;
   assign e_div = (e_rate <= port_cfg_pkg::RATE_MAX) ? div_tab[e_rate[3:0]] : div_tab[0];

   logic tx_idle;
   logic apply;
   assign tx_idle = (tx_st_q == port_cfg_pkg::S_IDLE);
   assign apply = SETTINGS_CHANGING && (CYCLE_START || imm_q) && tx_idle
                  && rx_st_q == port_cfg_pkg::S_IDLE;

   // Pending flag: a write in the applying cycle keeps it set
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         SETTINGS_CHANGING <= 1'b0;
         imm_q <= 1'b0;
      end
      else
      begin
         if (cfg_wr || instr_wr)
            SETTINGS_CHANGING <= 1'b1;
         else if (apply)
            SETTINGS_CHANGING <= 1'b0;
         if (instr_wr)
            imm_q <= 1'b1;
         else if (apply)
            imm_q <= 1'b0;
      end
   end

   // Applied settings
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         bits8_q <= 1'b0;
         stop1_q <= 1'b0;
         par_q <= port_cfg_pkg::PAR_EVEN;
         div_q <= div_tab[port_cfg_pkg::RATE_STD[3:0]];
         PBUS_MODE <= 1'b0;
      end
      else if (apply)
      begin
         bits8_q <= cust && fmt_q[port_cfg_pkg::BITS8_BIT];
         stop1_q <= cust && fmt_q[port_cfg_pkg::STOP1_BIT];
         par_q <= cust ? fmt_q[1:0] : port_cfg_pkg::PAR_EVEN;
         div_q <= e_div;
         PBUS_MODE <= (mode == port_cfg_pkg::MODE_PBUS);
      end
   end

   // Transmit path
   logic tx_valid;
   logic [7:0] tx_data;
   buf2 #(.W(8)) u_txbuf (
      .clk(CLOCK), .rst(RST), .in_valid(tx_push), .in_data(DAT_I[7:0]),
      .in_ready(tx_in_ready), .out_valid(tx_valid), .out_data(tx_data), .out_ready(tx_idle));

   logic [DIV_W-1:0] tx_tmr_q;
   logic [7:0] tx_sh_q;
   logic [2:0] tx_cnt_q;
   logic tx_par_q;
   logic [2:0] last_bit;
   assign last_bit = bits8_q ? 3'h7 : 3'h6;

   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         tx_st_q <= port_cfg_pkg::S_IDLE;
         TXD <= 1'b1;
         tx_tmr_q <= '0;
         tx_sh_q <= '0;
         tx_cnt_q <= '0;
         tx_par_q <= 1'b0;
      end
      else if (tx_st_q == port_cfg_pkg::S_IDLE)
      begin
         TXD <= 1'b1;
         if (tx_valid)
         begin
            tx_st_q <= port_cfg_pkg::S_START;
            TXD <= 1'b0;
            tx_tmr_q <= div_q - 1'b1;
            tx_sh_q <= tx_data;
            tx_par_q <= ^(tx_data & {bits8_q, 7'h7F}) ^ (par_q == port_cfg_pkg::PAR_ODD);
            tx_cnt_q <= '0;
         end
      end
      else if (tx_tmr_q != '0)
         tx_tmr_q <= tx_tmr_q - 1'b1;
      else
      begin
         tx_tmr_q <= div_q - 1'b1;
         unique case (tx_st_q)
            port_cfg_pkg::S_START:
            begin
               tx_st_q <= port_cfg_pkg::S_DATA;
               TXD <= tx_sh_q[0];
            end
            port_cfg_pkg::S_DATA:
            begin
               tx_sh_q <= tx_sh_q >> 1;
               tx_cnt_q <= tx_cnt_q + 1'b1;
               TXD <= tx_sh_q[1];
               if (tx_cnt_q == last_bit)
               begin
                  tx_cnt_q <= '0;
                  tx_st_q <= par_q[1] ? port_cfg_pkg::S_STOP : port_cfg_pkg::S_PAR;
                  TXD <= par_q[1] ? 1'b1 : tx_par_q;
               end
            end
            port_cfg_pkg::S_PAR:
            begin
               tx_st_q <= port_cfg_pkg::S_STOP;
               TXD <= 1'b1;
            end
            port_cfg_pkg::S_STOP:
            begin
               tx_cnt_q <= tx_cnt_q + 1'b1;
               if (stop1_q || tx_cnt_q != '0)
                  tx_st_q <= port_cfg_pkg::S_IDLE;
            end
            default: tx_st_q <= port_cfg_pkg::S_IDLE;
         endcase
      end
   end

   // Receive path
   logic rx_in_ready;
   logic rx_push_q;
   logic [DIV_W-1:0] rx_tmr_q;
   logic [7:0] rx_sh_q;
   logic [2:0] rx_cnt_q;
   buf2 #(.W(8)) u_rxbuf (
      .clk(CLOCK), .rst(RST), .in_valid(rx_push_q), .in_data(rx_sh_q),
      .in_ready(rx_in_ready), .out_valid(rx_valid), .out_data(rx_data), .out_ready(rx_pop));

   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         rx_st_q <= port_cfg_pkg::S_IDLE;
         rx_tmr_q <= '0;
         rx_sh_q <= '0;
         rx_cnt_q <= '0;
         rx_push_q <= 1'b0;
         perr_q <= 1'b0;
         ferr_q <= 1'b0;
         ovr_q <= 1'b0;
      end
      else
      begin
         rx_push_q <= 1'b0;
         if (err_clr)
         begin
            perr_q <= perr_q && !DAT_I[port_cfg_pkg::ST_PERR];
            ferr_q <= ferr_q && !DAT_I[port_cfg_pkg::ST_FERR];
            ovr_q <= ovr_q && !DAT_I[port_cfg_pkg::ST_OVR];
         end
         if (rx_st_q == port_cfg_pkg::S_IDLE)
         begin
            if (!RXD)
            begin
               rx_st_q <= port_cfg_pkg::S_START;
               rx_tmr_q <= div_q >> 1;
               rx_cnt_q <= '0;
               rx_sh_q <= '0;
            end
         end
         else if (rx_tmr_q != '0)
            rx_tmr_q <= rx_tmr_q - 1'b1;
         else
         begin
            rx_tmr_q <= div_q - 1'b1;
            unique case (rx_st_q)
               port_cfg_pkg::S_START:
                  rx_st_q <= RXD ? port_cfg_pkg::S_IDLE : port_cfg_pkg::S_DATA;
               port_cfg_pkg::S_DATA:
               begin
                  rx_sh_q[rx_cnt_q] <= RXD;
                  rx_cnt_q <= rx_cnt_q + 1'b1;
                  if (rx_cnt_q == last_bit)
                     rx_st_q <= par_q[1] ? port_cfg_pkg::S_STOP : port_cfg_pkg::S_PAR;
               end
               port_cfg_pkg::S_PAR:
               begin
                  rx_st_q <= port_cfg_pkg::S_STOP;
                  if (RXD != (^rx_sh_q ^ (par_q == port_cfg_pkg::PAR_ODD)))
                     perr_q <= 1'b1;
               end
               port_cfg_pkg::S_STOP:
               begin
                  rx_st_q <= port_cfg_pkg::S_IDLE;
                  if (!RXD)
                     ferr_q <= 1'b1;
                  if (rx_in_ready)
                     rx_push_q <= 1'b1;
                  else
                     ovr_q <= 1'b1;
               end
               default: rx_st_q <= port_cfg_pkg::S_IDLE;
            endcase
         end
      end
   end

   // Checks
   std_format_a: assert property (@(posedge CLOCK) disable iff (RST)
      apply && !fmt_q[port_cfg_pkg::SEL_BIT] |=> !bits8_q && !stop1_q && par_q == 2'h0
      && div_q == DIV_W'(CLK_HZ / 9600)) else $error("standard format not applied");
   mode_ignore_a: assert property (@(posedge CLOCK) disable iff (RST)
      apply && !host |=> !bits8_q && !stop1_q && par_q == 2'h0
      && div_q == DIV_W'(CLK_HZ / 9600)) else $error("fields used outside host link");
   default_rate_a: assert property (@(posedge CLOCK) disable iff (RST)
      apply && cust && rate_q[7:0] == 8'h00 |=> div_q == DIV_W'(CLK_HZ / 9600))
      else $error("rate code 00 not 9600");
   top_rate_a: assert property (@(posedge CLOCK) disable iff (RST)
      apply && cust && rate_q[7:0] == 8'h0A |=> div_q == DIV_W'(CLK_HZ / 115200))
      else $error("rate code 0A not 115200");
   data_len_a: assert property (@(posedge CLOCK) disable iff (RST)
      apply && cust |=> bits8_q == $past(fmt_q[port_cfg_pkg::BITS8_BIT]))
      else $error("data length wrong");
   stop_len_a: assert property (@(posedge CLOCK) disable iff (RST)
      apply && cust |=> stop1_q == $past(fmt_q[port_cfg_pkg::STOP1_BIT]))
      else $error("stop length wrong");
   parity_sel_a: assert property (@(posedge CLOCK) disable iff (RST)
      apply && cust && fmt_q[1:0] == 2'h1 |=> par_q == 2'h1) else $error("odd parity lost");
   host_mode_a: assert property (@(posedge CLOCK) disable iff (RST)
      apply && fmt_q[port_cfg_pkg::SEL_BIT] && mode == port_cfg_pkg::MODE_HOST5
      && rate_q[7:0] == 8'h07 |=> div_q == DIV_W'(CLK_HZ / 19200))
      else $error("mode 5 not host link");
   flag_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
      apply && !cfg_wr && !instr_wr |=> !SETTINGS_CHANGING) else $error("flag not cleared");
   flag_set_a: assert property (@(posedge CLOCK) disable iff (RST)
      cfg_wr |=> SETTINGS_CHANGING && ($stable(div_q) || $past(apply)))
      else $error("write applied early");
   pbus_mode_a: assert property (@(posedge CLOCK) disable iff (RST)
      apply && mode == 4'h4 |=> PBUS_MODE) else $error("peripheral bus mode missed");
endmodule // peripheral_port_serial_config

`default_nettype wire

// ### rtl/port_cfg_pkg.sv
/*
 Constants for the peripheral serial port: register indices, field
 positions, codes and the bit-rate table.
 Assumes a Wishbone slave that multiplies each index by four.
*/
`default_nettype none

package port_cfg_pkg;
   localparam logic [7:0] IDX_FMT = 8'h90;
   localparam logic [7:0] IDX_RATE = 8'h91;
   localparam logic [7:0] IDX_DATA = 8'h92;
   localparam logic [7:0] IDX_STAT = 8'h93;
   localparam logic [7:0] IDX_CTRL = 8'h94;
   localparam logic [15:0] FMT_RST = 16'h0000;
   localparam logic [15:0] RATE_RST = 16'h0000;
   localparam int SEL_BIT = 15;
   localparam int MODE_LSB = 8;
   localparam int BITS8_BIT = 3;
   localparam int STOP1_BIT = 2;
   localparam logic [3:0] MODE_HOST0 = 4'h0;
   localparam logic [3:0] MODE_HOST5 = 4'h5;
   localparam logic [3:0] MODE_PBUS = 4'h4;
   localparam logic [1:0] PAR_EVEN = 2'h0;
   localparam logic [1:0] PAR_ODD = 2'h1;
   localparam logic [7:0] RATE_STD = 8'h06;
   localparam logic [7:0] RATE_MAX = 8'h0A;
   localparam int RATE_LOW = 300;
   localparam int RATE_HIGH = 115200;
   localparam int ST_TXRDY = 0;
   localparam int ST_RXVAL = 1;
   localparam int ST_CHG = 2;
   localparam int ST_PERR = 3;
   localparam int ST_FERR = 4;
   localparam int ST_OVR = 5;
   localparam int RX_VALID_BIT = 8;

   typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} line_state_e;

   function automatic int baud_of(input logic [7:0] code);
      case (code)
         8'h01: return 300;
         8'h02: return 600;
         8'h03: return 1200;
         8'h04: return 2400;
         8'h05: return 4800;
         8'h07: return 19200;
         8'h08: return 38400;
         8'h09: return 57600;
         8'h0A: return 115200;
         default: return 9600;
      endcase
   endfunction
endpackage

`default_nettype wire

// ### verification/serial_host.sv
/*
 Serial host model standing at the far end of the peripheral port.
 Assumes it shares the port's clock and that the line idles high.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_host
(
   // Clock
   input wire logic clk,
   // Serial line
   input wire logic txd,
   output logic rxd
);
   initial rxd = 1'b1;

   // Samples one frame mid-bit; the start bit sets the bit time
   task automatic recv(input int nb, input bit hp, output int n, output logic [7:0] d,
         output logic p, output logic s, output logic nx);
      n = 0;
      d = 8'h00;
      p = 1'b0;
      while (txd !== 1'b0) @(posedge clk);
      while (txd === 1'b0)
      begin
         n++;
         @(posedge clk);
      end
      repeat (n / 2) @(posedge clk);
      for (int i = 0; i < nb; i++)
      begin
         d[i] = txd;
         repeat (n) @(posedge clk);
      end
      if (hp)
      begin
         p = txd;
         repeat (n) @(posedge clk);
      end
      s = txd;
      repeat (n) @(posedge clk);
      nx = txd;
   endtask

   // Sends one frame LSB first, then returns the line to idle high
   task automatic send(input int n, input int nb, input bit hp, input logic p,
         input logic [7:0] d);
      @(posedge clk);
      rxd <= 1'b0;
      repeat (n) @(posedge clk);
      for (int i = 0; i < nb; i++)
      begin
         rxd <= d[i];
         repeat (n) @(posedge clk);
      end
      if (hp)
      begin
         rxd <= p;
         repeat (n) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (2 * n) @(posedge clk);
   endtask
endmodule // serial_host

`default_nettype wire

// ### verification/tb.sv
/*
 Self-checking testbench for the peripheral serial port setup block.
 Assumes the serial host model; the port clock rate is scaled down.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
   localparam int HZ = 500000;
   localparam logic [7:0] FMT = port_cfg_pkg::IDX_FMT;
   localparam logic [7:0] RATE = port_cfg_pkg::IDX_RATE;
   localparam logic [7:0] DATA = port_cfg_pkg::IDX_DATA;
   localparam logic [7:0] STAT = port_cfg_pkg::IDX_STAT;
   localparam logic [7:0] CTRL = port_cfg_pkg::IDX_CTRL;
   logic clk, rst, cyc, stb, we, cs, ack, txd, rxd, chg, pbus;
   logic [11:0] adr;
   logic [3:0] sel;
   logic [31:0] dat, dat_o;
   int n_fail = 0;
   int n_tests = 0;
   int rates [11] = '{9600, 300, 600, 1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};

   peripheral_port_serial_config #(.CLK_HZ(HZ)) u_dut (.CLOCK(clk), .RST(rst), .CYC_I(cyc),
      .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o),
      .ACK_O(ack), .CYCLE_START(cs), .RXD(rxd), .TXD(txd), .SETTINGS_CHANGING(chg),
      .PBUS_MODE(pbus));
   serial_host u_host (.clk(clk), .txd(txd), .rxd(rxd));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      n_tests++;
      if (g !== e)
      begin
         n_fail++;
         $display("ERROR %0t %s: got %0h, expected %0h", $time, m, g, e);
      end
   endtask

   task automatic chkb(input logic g, input logic e, input string m);
      chk({31'h0, g}, {31'h0, e}, m);
   endtask

   task automatic chkn(input int g, input int e, input string m);
      chk(32'(g), 32'(e), m);
   endtask

   // Classic single cycle; holds the request until ack is sampled
   task automatic wb(input logic w, input logic [7:0] i, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {2'b00, i, 2'b00};
      sel <= 4'hF;
      dat <= d;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] i, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, i, 32'h0, q);
      chk(q & m, e, "register read");
   endtask

   task automatic cfg(input logic [15:0] f, input logic [7:0] r);
      logic [31:0] q;
      wb(1'b1, FMT, {16'h0, f}, q);
      wb(1'b1, RATE, {24'h0, r}, q);
      chkb(chg, 1'b1, "flag raised");
      rd(FMT, 32'hFFFF, {16'h0, f});
      @(posedge clk);
      cs <= 1'b1;
      @(posedge clk);
      cs <= 1'b0;
      @(posedge clk);
      chkb(chg, 1'b0, "flag cleared");
   endtask

   // Two bytes back to back; the bit after the first stop tells the stop count
   task automatic frame(input int nb, input bit hp, input bit odd, input bit two, input int dv);
      logic [31:0] q;
      logic [7:0] d, e;
      logic p, s, nx;
      int n;
      e = (nb == 7) ? 8'h35 : 8'hB5;
      fork
         u_host.recv(nb, hp, n, d, p, s, nx);
         begin
            wb(1'b1, DATA, 32'hB5, q);
            wb(1'b1, DATA, 32'hB5, q);
         end
      join
      chkn(n, dv, "bit time");
      chk({24'h0, d}, {24'h0, e}, "data bits");
      if (hp)
         chkb(p, ^e ^ odd, "parity");
      chkb(s, 1'b1, "first stop");
      chkb(nx, two, "stop count");
      repeat (14 * dv) @(posedge clk);
   endtask

   task automatic s_reset();
      logic [31:0] q;
      chkb(chg, 1'b0, "flag after reset");
      chkb(pbus, 1'b0, "mode after reset");
      rd(FMT, 32'hFFFF, 32'h0);
      rd(RATE, 32'hFFFF, 32'h0);
      rd(CTRL, 32'h3F, 32'h0);
      wb(1'b1, 8'hA0, 32'hFFFF, q);
      rd(8'hA0, 32'hFFFFFFFF, 32'h0);
      frame(7, 1'b1, 1'b0, 1'b1, HZ / 9600);
   endtask

   task automatic s_format();
      cfg(16'h800D, 8'h0A);
      frame(8, 1'b1, 1'b1, 1'b0, HZ / 115200);
      cfg(16'h8002, 8'h0A);
      frame(7, 1'b0, 1'b0, 1'b1, HZ / 115200);
      cfg(16'h8508, 8'h07);
      frame(8, 1'b1, 1'b0, 1'b1, HZ / 19200);
      cfg(16'h000D, 8'h0A);
      frame(7, 1'b1, 1'b0, 1'b1, HZ / 9600);
      cfg(16'h820D, 8'h0A);
      rd(CTRL, 32'h3E, 32'h0);
      cfg(16'h840D, 8'h0A);
      chkb(pbus, 1'b1, "bus mode");
      rd(CTRL, 32'h3E, 32'h20);
   endtask

   task automatic s_instr();
      logic [31:0] q;
      wb(1'b1, FMT, 32'h800D, q);
      rd(CTRL, 32'h3E, 32'h20);
      wb(1'b1, CTRL, 32'h1, q);
      for (int i = 0; i < 50 && chg !== 1'b0; i++) @(posedge clk);
      chkb(chg, 1'b0, "applied by instruction");
      chkb(pbus, 1'b0, "back to host link");
      rd(CTRL, 32'h3F, 32'h1A);
   endtask

   task automatic s_burst();
      logic [31:0] q;
      logic [7:0] d [4];
      logic p, s, nx;
      int n;
      cfg(16'h800A, 8'h0A);
      fork
         for (int i = 0; i < 4; i++)
            u_host.recv(8, 1'b0, n, d[i], p, s, nx);
         for (int i = 0; i < 4; i++)
         begin
            wb(1'b1, DATA, 32'h11 + 32'(2 * i), q);
            if (i == 2)
               rd(STAT, 32'h1, 32'h0);
         end
      join
      for (int i = 0; i < 4; i++)
         chk({24'h0, d[i]}, 32'h11 + 32'(2 * i), "burst byte");
      rd(STAT, 32'h1, 32'h1);
   endtask

   task automatic s_rx();
      logic [31:0] q;
      for (int i = 0; i < 3; i++)
         u_host.send(HZ / 115200, 8, 1'b0, 1'b0, 8'hA1 + 8'(i));
      rd(STAT, 32'h22, 32'h22);
      rd(DATA, 32'h1FF, 32'h1A1);
      rd(DATA, 32'h1FF, 32'h1A2);
      rd(DATA, 32'h100, 32'h0);
      wb(1'b1, STAT, 32'h38, q);
      rd(STAT, 32'h38, 32'h0);
   endtask

   task automatic s_rate();
      logic [31:0] q;
      logic [7:0] d;
      logic p, s, nx;
      int n;
      for (int c = 0; c <= 10; c++)
      begin
         cfg(16'h800E, c[7:0]);
         fork
            u_host.recv(8, 1'b0, n, d, p, s, nx);
            wb(1'b1, DATA, 32'hB5, q);
         join
         chkn(n, HZ / rates[c], "rate");
         repeat (2 * n) @(posedge clk);
      end
   endtask

   initial
   begin
      repeat (90000) @(posedge clk);
      n_fail++;
      $display("ERROR %0t watchdog expired", $time);
      end_sim();
   end

   initial
   begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      cs = 1'b0;
      adr = 12'h000;
      sel = 4'h0;
      dat = 32'h0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      s_reset();
      s_format();
      s_instr();
      s_burst();
      s_rx();
      s_rate();
      end_sim();
   end
endmodule // tb

`default_nettype wire
